// File: logic/mmrd_pkg.sv
package mmrd_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int unsigned NUM_MST   = 2;
   localparam int unsigned NUM_SLV   = 4;   // regular slaves plus the default slave
   localparam int unsigned DEF_SLV   = 3;   // index of the default slave
   localparam int unsigned ADDR_W    = 32;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned MST_IDX_W = 1;
   localparam int unsigned SLV_IDX_W = 2;
   localparam int unsigned PARTS_W   = 2;
   localparam int unsigned RESP_W    = 2;

   // ----------------------------------------------------------------
   // memory map: base must be a multiple of 2**span
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] SLV_BASE [NUM_SLV] = '{
      32'h0000_0000, 32'h0001_0000, 32'h0002_0000, 32'h0000_0000};
   localparam int unsigned SLV_SPAN_LOG2 [NUM_SLV] = '{16, 12, 8, 0};

   // per-slave attributes, bit j belongs to slave j
   localparam logic [NUM_SLV-1:0] SLV_SECURE_ONLY   = 4'h2;
   localparam logic [NUM_SLV-1:0] SLV_HAS_RESP      = 4'hD;
   localparam logic [NUM_SLV-1:0] SLV_BRIDGE_NORESP = 4'h4;
   // per-master attribute, bit i belongs to master i
   localparam logic [NUM_MST-1:0] MST_HAS_RESP      = 2'h1;

   // address step between the parts of a split transfer
   localparam logic [ADDR_W-1:0] PART_STEP = 32'h0000_0004;

   // ----------------------------------------------------------------
   // response codes
   // ----------------------------------------------------------------
   localparam logic [RESP_W-1:0] RESP_OKAY   = 2'h0;
   localparam logic [RESP_W-1:0] RESP_EXOKAY = 2'h1;
   localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
   localparam logic [RESP_W-1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_DONE} mmrd_state_t;

   // severity: decerr > slverr > okay > exokay
   function automatic logic [RESP_W-1:0] mmrd_rank(input logic [RESP_W-1:0] r);
      mmrd_rank = (r == RESP_OKAY)   ? 2'h1 :
                  (r == RESP_EXOKAY) ? 2'h0 : r;
   endfunction : mmrd_rank

   function automatic logic [RESP_W-1:0] mmrd_worse(input logic [RESP_W-1:0] a,
                                                   input logic [RESP_W-1:0] b);
      mmrd_worse = (mmrd_rank(b) > mmrd_rank(a)) ? b : a;
   endfunction : mmrd_worse

endpackage : mmrd_pkg

// File: logic/mmrd_addr_decode.sv
`timescale 1ns/1ps
`default_nettype none

module mmrd_addr_decode
   import mmrd_pkg::*;
(
   input  wire logic [ADDR_W-1:0]  addr,
   input  wire logic               secure,
   output logic      [NUM_SLV-1:0] hit,
   output logic      [ADDR_W-1:0]  localAddr
);

   logic [NUM_SLV-1:0] rawHit;
   logic [NUM_SLV:0]   seen;
   logic [ADDR_W-1:0]  locAcc [NUM_SLV+1];

   assign seen[0]   = 1'b0;
   assign locAcc[0] = '0;

   // ----------------------------------------------------------------
   // per-slave window compare and local address
   // ----------------------------------------------------------------
   genvar j;
   generate
      for (j = 0; j < NUM_SLV; j++)
      begin : g_slv
         localparam logic [ADDR_W-1:0] SPAN_MASK =
            (ADDR_W'(1) << SLV_SPAN_LOG2[j]) - ADDR_W'(1);
         if (j == DEF_SLV)
         begin : g_def
            // illegal address or security violation lands here
            assign rawHit[j] = 1'b1;
         end
         else
         begin : g_reg
            // only bits above the span are compared
            assign rawHit[j] = ((addr >> SLV_SPAN_LOG2[j]) == (SLV_BASE[j] >> SLV_SPAN_LOG2[j]))
                               && (secure || !SLV_SECURE_ONLY[j]);
         end
         // first hit wins, so exactly one select
         assign hit[j]      = rawHit[j] && !seen[j];
         assign seen[j+1]   = seen[j] || rawHit[j];
         // offset to local zero, upper bits dropped
         assign locAcc[j+1] = locAcc[j] | (hit[j] ? (addr & SPAN_MASK) : '0);
      end
   endgenerate

   assign localAddr = locAcc[NUM_SLV];

endmodule : mmrd_addr_decode

`default_nettype wire

// File: logic/mmrd_router.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - both ends respond: slave response goes back to the requesting master
// - split transfers get their responses merged to the master's own sizing
// - slave without response: interconnect returns OKAY itself
// - neither end responds: no response signalling, transfer still completes
// - bridge without responses: generate OKAY there, drop endpoint responses
// - illegal or insecure accesses go to the default slave
// - decoder raises the addressed slave's select
// - slave address is offset to start at local zero
// - one address decoder per master
// - slave sees only the address bits within its span
// - base is a multiple of span; compare only bits above span
// - merged response is the most severe: DECERR, SLVERR, OKAY, EXOKAY
// - split writes and downsized reads return one merged response
module mmrd_router
   import mmrd_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic [NUM_MST-1:0]   mReq,
   input  wire logic [ADDR_W-1:0]    mAddr       [NUM_MST],
   input  wire logic [NUM_MST-1:0]   mWrite,
   input  wire logic [NUM_MST-1:0]   mSecure,
   input  wire logic [PARTS_W-1:0]   mParts      [NUM_MST],
   input  wire logic [DATA_W-1:0]    mWdata      [NUM_MST],
   output logic      [NUM_MST-1:0]   mAck,
   output logic      [NUM_MST-1:0]   mRespValid,
   output logic      [RESP_W-1:0]    mResp,
   output logic      [DATA_W-1:0]    mRdata,
   output logic      [NUM_SLV-1:0]   sSel,
   output logic      [ADDR_W-1:0]    sAddr,
   output logic                      sWrite,
   output logic      [DATA_W-1:0]    sWdata,
   input  wire logic [NUM_SLV-1:0]   sRespValid,
   input  wire logic [RESP_W-1:0]    sResp       [NUM_SLV],
   input  wire logic [DATA_W-1:0]    sRdata      [NUM_SLV]
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   mmrd_state_t          state_r;
   mmrd_state_t          state_nxt;
   logic [MST_IDX_W-1:0] grant_r;
   logic [SLV_IDX_W-1:0] tgt_r;
   logic [ADDR_W-1:0]    addr_r;
   logic [PARTS_W-1:0]   partsLeft_r;
   logic [RESP_W-1:0]    merged_r;
   logic                 first_r;
   logic [NUM_MST-1:0]   mAck_r;
   logic [NUM_MST-1:0]   mRespValid_r;
   logic [RESP_W-1:0]    mResp_r;
   logic [DATA_W-1:0]    mRdata_r;
   logic [NUM_SLV-1:0]   sSel_r;
   logic [ADDR_W-1:0]    sAddr_r;
   logic                 sWrite_r;
   logic [DATA_W-1:0]    sWdata_r;

   // ----------------------------------------------------------------
   // decoders, one per master
   // ----------------------------------------------------------------
   logic [NUM_SLV-1:0]   hitM  [NUM_MST];
   logic [ADDR_W-1:0]    locM  [NUM_MST];
   logic [NUM_MST:0]     reqSeen;
   logic [MST_IDX_W-1:0] gntAcc [NUM_MST+1];

   assign reqSeen[0] = 1'b0;
   assign gntAcc[0]  = '0;

   genvar i;
   generate
      for (i = 0; i < NUM_MST; i++)
      begin : g_mst
         mmrd_addr_decode u_dec (
            .addr      (mAddr[i]),
            .secure    (mSecure[i]),
            .hit       (hitM[i]),
            .localAddr (locM[i])
         );
         // fixed priority, lowest index first
         assign gntAcc[i+1]  = gntAcc[i] |
                               ((mReq[i] && !reqSeen[i]) ? MST_IDX_W'(i) : '0);
         assign reqSeen[i+1] = reqSeen[i] || mReq[i];
      end
   endgenerate

   wire                 reqAny = reqSeen[NUM_MST];
   wire [MST_IDX_W-1:0] gntIdx = gntAcc[NUM_MST];

   // one-hot hit of the granted master to slave index
   logic [SLV_IDX_W-1:0] tgtAcc [NUM_SLV+1];
   assign tgtAcc[0] = '0;

   genvar j;
   generate
      for (j = 0; j < NUM_SLV; j++)
      begin : g_tgt
         assign tgtAcc[j+1] = tgtAcc[j] | (hitM[gntIdx][j] ? SLV_IDX_W'(j) : '0);
      end
   endgenerate

   wire [SLV_IDX_W-1:0] tgtIdx = tgtAcc[NUM_SLV];

   // ----------------------------------------------------------------
   // response handling
   // ----------------------------------------------------------------
   // a non-responding bridge masks the endpoint's response
   wire tgtResponds = SLV_HAS_RESP[tgt_r] && !SLV_BRIDGE_NORESP[tgt_r];
   // without a response path the part ends in the same cycle that select is high
   wire partDone = (state_r == ST_WAIT) && (!tgtResponds || sRespValid[tgt_r]);
   // pass through unchanged, or stand in with okay
   wire [RESP_W-1:0] partResp = tgtResponds ? sResp[tgt_r] : RESP_OKAY;
   // worst response wins across parts
   wire [RESP_W-1:0] mergedNxt = first_r ? partResp : mmrd_worse(merged_r, partResp);
   wire lastPart = (partsLeft_r == '0);

   // later parts wrap inside the target's span, no bit above it leaks
   wire [ADDR_W-1:0] spanMask = (ADDR_W'(1) << SLV_SPAN_LOG2[tgt_r]) - ADDR_W'(1);
   wire [ADDR_W-1:0] nextAddr = (addr_r + PART_STEP) & spanMask;

   // done always falls back to idle: one idle cycle between grants
   assign state_nxt = (state_r == ST_IDLE)  ? (reqAny ? ST_ISSUE : ST_IDLE) :
                      (state_r == ST_ISSUE) ? ST_WAIT :
                      (state_r == ST_WAIT)  ? (!partDone ? ST_WAIT :
                                               lastPart  ? ST_DONE : ST_ISSUE) :
                      ST_IDLE;

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_r      <= ST_IDLE;
         grant_r      <= '0;
         tgt_r        <= '0;
         addr_r       <= '0;
         partsLeft_r  <= '0;
         merged_r     <= RESP_OKAY;
         first_r      <= 1'b0;
         mAck_r       <= '0;
         mRespValid_r <= '0;
         mResp_r      <= RESP_OKAY;
         mRdata_r     <= '0;
         sSel_r       <= '0;
         sAddr_r      <= '0;
         sWrite_r     <= 1'b0;
         sWdata_r     <= '0;
      end
      else
      begin
         state_r      <= state_nxt;
         sSel_r       <= '0;
         mAck_r       <= '0;
         mRespValid_r <= '0;
         unique case (state_r)
            ST_IDLE:
               // busy requests wait here; the master keeps its request up
               if (reqAny)
               begin
                  grant_r     <= gntIdx;
                  tgt_r       <= tgtIdx;
                  addr_r      <= locM[gntIdx];
                  sWrite_r    <= mWrite[gntIdx];
                  sWdata_r    <= mWdata[gntIdx];
                  partsLeft_r <= mParts[gntIdx];
                  first_r     <= 1'b1;
               end
            ST_ISSUE:
            begin
               sSel_r[tgt_r] <= 1'b1;
               sAddr_r       <= addr_r;
            end
            ST_WAIT:
               if (partDone)
               begin
                  merged_r <= mergedNxt;
                  first_r  <= 1'b0;
                  if (tgtResponds)
                     mRdata_r <= sRdata[tgt_r];
                  if (lastPart)
                  begin
                     // one merged answer per master transfer
                     mAck_r[grant_r]       <= 1'b1;
                     // only a responding master gets a response
                     mRespValid_r[grant_r] <= MST_HAS_RESP[grant_r];
                     mResp_r               <= mergedNxt;
                  end
                  else
                  begin
                     partsLeft_r <= partsLeft_r - PARTS_W'(1);
                     addr_r      <= nextAddr;
                  end
               end
            ST_DONE:
               first_r <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from flops
   // ----------------------------------------------------------------
   assign mAck       = mAck_r;
   assign mRespValid = mRespValid_r;
   assign mResp      = mResp_r;
   assign mRdata     = mRdata_r;
   assign sSel       = sSel_r;
   assign sAddr      = sAddr_r;
   assign sWrite     = sWrite_r;
   assign sWdata     = sWdata_r;

endmodule : mmrd_router

`default_nettype wire

// File: tb/mmrd_router_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mmrd_router_properties
   import mmrd_pkg::*;
(
   input wire logic               clk,
   input wire logic               srst,
   input wire logic [NUM_MST-1:0] mReq,
   input wire logic [NUM_MST-1:0] mAck,
   input wire logic [NUM_MST-1:0] mRespValid,
   input wire logic [NUM_SLV-1:0] sSel,
   input wire logic [ADDR_W-1:0]  sAddr
);
   // ----
   // transfer steps
   // ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_start; $rose(|mReq); endsequence
   sequence s_sel; sSel != '0; endsequence
   a_sel_onehot: assert property ($onehot0(sSel))
      else $error("more than one slave select");
   a_grant_sel: assert property (s_start |-> ##2 s_sel)
      else $error("select not raised two cycles after grant");
   a_sel_ends: assert property (s_sel |-> ##[1:40] (sSel != '0 || mAck != '0))
      else $error("transfer never completed");
   a_ack_owner: assert property ((mAck & ~mReq) == '0)
      else $error("ack to an idle master");
   a_resp_ack: assert property (mRespValid == (mAck & MST_HAS_RESP))
      else $error("response strobe disagrees with ack");
   a_ack_single: assert property (mAck != '0 |=> mAck == '0)
      else $error("more than one ack per transfer");
   a_def_local: assert property (sSel[DEF_SLV] |-> sAddr == '0)
      else $error("default slave address not zero");
   a_span_big: assert property (sSel[0] |-> sAddr[31:16] == '0)
      else $error("slave 0 sees bits above span");
   a_span_mid: assert property (sSel[1] |-> sAddr[31:12] == '0)
      else $error("slave 1 sees bits above span");
   a_span_small: assert property (sSel[2] |-> sAddr[31:8] == '0)
      else $error("slave 2 sees bits above span");
endmodule : mmrd_router_properties
bind mmrd_router mmrd_router_properties u_props (.clk(clk), .srst(srst), .mReq(mReq),
   .mAck(mAck), .mRespValid(mRespValid), .sSel(sSel), .sAddr(sAddr));
`default_nettype wire

// File: tb/mmrd_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmrd_slave_model
   import mmrd_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic [NUM_SLV-1:0] sSel,
   input  wire logic [ADDR_W-1:0]  sAddr,
   input  wire logic [3:0]         lat,
   input  wire logic [RESP_W-1:0]  code       [NUM_SLV],
   output logic      [NUM_SLV-1:0] sRespValid,
   output logic      [RESP_W-1:0]  sResp      [NUM_SLV],
   output logic      [DATA_W-1:0]  sRdata     [NUM_SLV]
);
   // ----
   // slaves
   // ----
   logic [NUM_SLV-1:0] pend_r;
   logic [3:0]         cnt_r;
   logic [DATA_W-1:0]  dat_r;
   logic [RESP_W-1:0]  code_r     [NUM_SLV];
   // all slaves answer, also non-responding ones and the bridge: the router must drop those
   always_ff @(posedge clk)
   begin
      sRespValid <= '0;
      if (srst)
         pend_r <= '0;
      else if (sSel != '0)
      begin
         pend_r <= sSel;
         cnt_r  <= lat;
         dat_r  <= sAddr ^ 32'h5A5A_0000;
         code_r <= code;
      end
      else if (pend_r != '0 && cnt_r == '0)
      begin
         sRespValid <= pend_r;
         pend_r     <= '0;
      end
      else
         cnt_r <= cnt_r - 4'h1;
   end
   // released lines invert so a stale value never passes
   for (genvar j = 0; j < NUM_SLV; j++)
   begin : g_line
      assign sResp[j]  = sRespValid[j] ? code_r[j] : ~code_r[j];
      assign sRdata[j] = sRespValid[j] ? dat_r : ~dat_r;
   end
endmodule : mmrd_slave_model
`default_nettype wire

// File: tb/mmrd_router_test.sv
`timescale 1ns/1ps
`default_nettype none
module mmrd_router_test
   import mmrd_pkg::*;
;
   typedef struct {int m; logic [31:0] a; logic s; logic [1:0] p;
      logic [1:0] rc; int es; logic [31:0] el; logic [1:0] er;} mmrd_row_t;
   // ----
   // cases
   // ----
   localparam int NR = 8;
   mmrd_row_t rows [NR] = '{
      '{0, 32'h0000_1234, 1, 0, RESP_OKAY, 0, 32'h0000_1234, RESP_OKAY},
      '{0, 32'h0000_0100, 0, 3, RESP_EXOKAY, 0, 32'h0000_0100, RESP_EXOKAY},
      '{0, 32'h0001_0ABC, 1, 0, RESP_OKAY, 1, 32'h0000_0ABC, RESP_OKAY},
      '{0, 32'h0001_0ABC, 0, 0, RESP_OKAY, 3, 32'h0000_0000, RESP_DECERR},
      '{0, 32'h0002_00F0, 0, 1, RESP_OKAY, 2, 32'h0000_00F0, RESP_OKAY},
      '{0, 32'h0002_0100, 0, 0, RESP_OKAY, 3, 32'h0000_0000, RESP_DECERR},
      '{0, 32'h0003_0000, 1, 0, RESP_OKAY, 3, 32'h0000_0000, RESP_DECERR},
      '{1, 32'h0000_0200, 0, 2, RESP_SLVERR, 0, 32'h0000_0200, RESP_OKAY}};
   logic [1:0] mg [5][3] = '{'{RESP_OKAY, RESP_SLVERR, RESP_SLVERR},
      '{RESP_SLVERR, RESP_OKAY, RESP_SLVERR}, '{RESP_EXOKAY, RESP_OKAY, RESP_OKAY},
      '{RESP_DECERR, RESP_SLVERR, RESP_DECERR}, '{RESP_OKAY, RESP_EXOKAY, RESP_OKAY}};
   logic clk, srst, done, gRv, gWr;
   logic [NUM_MST-1:0] mReq, mWrite, mSecure, mAck, mRespValid;
   logic [31:0] mAddr [NUM_MST], mWdata [NUM_MST], mRdata, sAddr, sWdata, gAddr, gData, gWd;
   logic [1:0] mParts [NUM_MST], mResp, sResp [NUM_SLV], code [NUM_SLV], gResp;
   logic [3:0] sSel, sRespValid, gSel, lat;
   logic [31:0] sRdata [NUM_SLV];
   logic sWrite;
   int miscompares = 0, comparisons = 0, cycles = 0, gN;
   mmrd_router dut (.clk(clk), .srst(srst), .mReq(mReq), .mAddr(mAddr), .mWrite(mWrite),
      .mSecure(mSecure), .mParts(mParts), .mWdata(mWdata), .mAck(mAck),
      .mRespValid(mRespValid), .mResp(mResp), .mRdata(mRdata), .sSel(sSel), .sAddr(sAddr),
      .sWrite(sWrite), .sWdata(sWdata), .sRespValid(sRespValid), .sResp(sResp),
      .sRdata(sRdata));
   mmrd_slave_model u_slv (.clk(clk), .srst(srst), .sSel(sSel), .sAddr(sAddr), .lat(lat),
      .code(code), .sRespValid(sRespValid), .sResp(sResp), .sRdata(sRdata));
   task automatic chk(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp)
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      if (seen !== exp)
         miscompares++;
   endtask : chk
   task automatic stop_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test
   // master keeps its request until it sees ack, as a real one must
   task automatic xfer(input int m, input logic [31:0] a, input logic s,
                       input logic [1:0] p, c1, c2);
      gN = 0;
      done = 0;
      @(posedge clk);
      mReq[m] <= 1'h1;
      mAddr[m] <= a;
      mSecure[m] <= s;
      mParts[m] <= p;
      mWrite[m] <= p[0];
      mWdata[m] <= ~a;
      code[0] <= c1;
      for (int i = 0; i < 60 && !done; i++)
      begin
         @(negedge clk);
         if (sSel != '0 && gN == 0) gSel = sSel;
         if (sSel != '0 && gN == 0) gAddr = sAddr;
         if (sSel != '0 && gN == 0) gWr = sWrite;
         if (sSel != '0 && gN == 0) gWd = sWdata;
         if (sSel != '0) gN++;
         done = mAck[m];
         gRv = mRespValid[m];
         gResp = mResp;
         gData = mRdata;
         @(posedge clk);
         if (gN == 1) code[0] <= c2;
      end
      mReq[m] <= 1'h0;
   endtask : xfer
   initial
   begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000) miscompares++;
      if (cycles == 3000) stop_test();
   end
   initial
   begin
      mmrd_row_t r;
      srst = 1'b1;
      mReq = '0;
      mWrite = '0;
      mSecure = '0;
      lat = '0;
      mAddr = '{default: '0};
      mWdata = '{default: '0};
      mParts = '{default: '0};
      code = '{RESP_OKAY, RESP_SLVERR, RESP_SLVERR, RESP_DECERR};
      repeat (12) @(posedge clk);
      srst <= 1'h0;
      @(negedge clk);
      chk("ack idle", mAck, 0);
      chk("select idle", sSel, 0);
      chk("response idle", mResp, RESP_OKAY);
      $display("reset done");
      for (int k = 0; k < NR; k++)
      begin
         r = rows[k];
         xfer(r.m, r.a, r.s, r.p, r.rc, r.rc);
         chk("ack", done, 1);
         chk("select", gSel, 1 << r.es);
         chk("local address", gAddr, r.el);
         chk("write flag", gWr, r.p[0]);
         chk("write data", gWd, ~r.a);
         chk("parts", gN, r.p + 1);
         chk("response valid", gRv, MST_HAS_RESP[r.m]);
         if (r.m == 0) chk("response", gResp, r.er);
         if (r.m == 0 && r.es != 1 && r.es != 2)
            chk("read data", gData, (r.el + 4 * r.p) ^ 32'h5A5A_0000);
         $display("row %0d done", k);
      end
      lat <= 4'h3;
      for (int i = 0; i < 5; i++)
      begin
         xfer(0, 32'h0000_0040, 0, 2'h1, mg[i][0], mg[i][1]);
         chk("merge parts", gN, 2);
         chk("merged response", gResp, mg[i][2]);
         $display("merge %0d done", i);
      end
      // reset in the middle of a transfer, then a clean restart
      xfer(0, 32'h0003_0000, 0, 2'h0, RESP_OKAY, RESP_OKAY);
      chk("response before reset", gResp, RESP_DECERR);
      @(posedge clk);
      mReq[0] <= 1'h1;
      mAddr[0] <= 32'h0000_0080;
      mParts[0] <= 2'h1;
      mWrite[0] <= 1'h1;
      mWdata[0] <= 32'hA5A5_0F0F;
      repeat (3) @(posedge clk);
      chk("address before reset", sAddr, 32'h0000_0080);
      srst <= 1'h1;
      mReq[0] <= 1'h0;
      repeat (2) @(posedge clk);
      srst <= 1'h0;
      @(negedge clk);
      chk("ack after reset", mAck, 0);
      chk("response valid after reset", mRespValid, 0);
      chk("response after reset", mResp, RESP_OKAY);
      chk("address after reset", sAddr, 0);
      chk("write after reset", sWrite, 0);
      chk("data after reset", sWdata, 0);
      $display("mid-run reset done");
      xfer(0, 32'h0000_0010, 0, 2'h0, RESP_SLVERR, RESP_SLVERR);
      chk("ack after restart", done, 1);
      chk("response after restart", gResp, RESP_SLVERR);
      chk("address after restart", gAddr, 32'h0000_0010);
      $display("restart done");
      stop_test();
   end
endmodule : mmrd_router_test
`default_nettype wire
